//--- bwe_pkg.sv
// bwe_pkg: shared constants and types for the byte-wide eeprom host controller
package bwe_pkg;

  // clock and pin timing, times in ns as printed, counts derived (least times round up)
  localparam int unsigned CLK_NS = 50;
  localparam int unsigned T_POWERUP_NS = 500000;
  localparam int unsigned T_SETUP_NS = 120;
  localparam int unsigned T_STROBE_PULSE_N_NS = 300;
  localparam int unsigned T_HOLD_NS = 60;
  localparam int unsigned T_ACCESS_NS = 450;
  localparam int unsigned T_GAP_NS = 350;
  localparam int unsigned POWERUP_CYC = (T_POWERUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned STROBE_PULSE_N_CYC = (T_STROBE_PULSE_N_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ACCESS_CYC = (T_ACCESS_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GAP_CYC = (T_GAP_NS + CLK_NS - 1) / CLK_NS;
  // two synchroniser stages sit in front of the sampled data port
  localparam int unsigned SYNC_CYC = 2;
  localparam int unsigned TMR_W = 16;

  // register byte offsets on the apb side
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_WDATA = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  // status word fields
  localparam int unsigned ST_CTRL_BUSY = 0;
  localparam int unsigned ST_PWR_OK = 1;
  localparam int unsigned ST_DEV_BUSY = 2;
  localparam int unsigned ST_RDATA_LSB = 8;
  localparam int unsigned ST_FLAGS_LSB = 16;
  // activity bit inside the device's activity_flags byte
  localparam int unsigned FLAG_ACTIVE = 7;

  // interrupt status and mask fields
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_DONE = 0;
  localparam int unsigned IRQ_READY = 1;
  localparam int unsigned IRQ_REFUSED = 2;

  // reset values
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] WDATA_RST = 8'h00;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // commands written to the command register
  typedef enum logic [2:0] {
    OP_NONE = 3'h0,
    OP_RD_WORD = 3'h1,
    OP_WR_WORD = 3'h2,
    OP_RD_STAT = 3'h3,
    OP_CLEAR = 3'h4
  } bwe_op_t;

  // pin sequencer states, gray along setup-strobe-hold-gap
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_SETUP = 3'b001,
    S_STROBE = 3'b011,
    S_HOLD = 3'b010,
    S_GAP = 3'b110
  } bwe_state_t;

  // registered levels of the device pins
  typedef struct packed {
    logic cs_n;
    logic rw;
    logic rs;
    logic strobe_pulse_n_n;
    logic clr_n;
    logic doe;
    logic [7:0] dout;
  } bwe_pins_t;

  localparam bwe_pins_t PINS_IDLE = '{cs_n: 1'b1, rw: 1'b1, rs: 1'b0, strobe_pulse_n_n: 1'b1,
                                      clr_n: 1'b1, doe: 1'b0, dout: 8'h00};

endpackage

//--- bwe_sync.sv
// bwe_sync: two flip-flop synchroniser for pin inputs
`timescale 1ns/1ps
module bwe_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // asynchronous in, synchronous out
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } bwe_sync_t;

  bwe_sync_t q_r;
  bwe_sync_t q_nxt;

  // first stage feeds only the second stage
  always_comb begin
    q_nxt.meta = async_i;
    q_nxt.stable = q_r.meta;
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q_r <= {RST_VAL, RST_VAL};
    end else begin
      q_r <= q_nxt;
    end
  end

  assign sync_o = q_r.stable;

endmodule

//--- bwe_timer.sv
// bwe_timer: loadable down counter that flags zero
`timescale 1ns/1ps
module bwe_timer #(
  parameter int unsigned W = 16,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // load request
  input wire logic load_i,
  input wire logic [W-1:0] load_val_i,
  // count reached zero
  output logic done_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
  } bwe_timer_t;

  bwe_timer_t q_r;
  bwe_timer_t q_nxt;

  // a load of n gives n+1 cycles until done; the count parks at zero
  always_comb begin
    q_nxt = q_r;
    if (load_i) begin
      q_nxt.cnt = load_val_i;
    end else if (q_r.cnt != '0) begin
      q_nxt.cnt = q_r.cnt - W'(1);
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q_r.cnt <= RST_VAL;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign done_o = (q_r.cnt == '0);

endmodule

//--- bwe_host.sv
// bwe_host: apb-controlled host that drives a byte-wide eeprom register port
`timescale 1ns/1ps
module bwe_host
  import bwe_pkg::*;
#(
  parameter int unsigned POWERUP_CYC_P = bwe_pkg::POWERUP_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [31:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // interrupt
  output logic irq_o,
  // device control pins
  output logic chip_select_n_o,
  output logic read_write_o,
  output logic register_select_o,
  output logic strobe_pulse_n_o,
  output logic array_clear_n_o,
  // device data port, two-way
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // device open-drain busy, low while programming
  input wire logic busy_n_i
);

  import bwe_pkg::*;

  localparam logic [TMR_W-1:0] LD_SETUP = TMR_W'(SETUP_CYC - 1);
  localparam logic [TMR_W-1:0] LD_STROBE_PULSE_N = TMR_W'(STROBE_PULSE_N_CYC - 1);
  localparam logic [TMR_W-1:0] LD_HOLD = TMR_W'(HOLD_CYC - 1);
  localparam logic [TMR_W-1:0] LD_READ = TMR_W'(ACCESS_CYC + SYNC_CYC - 1);
  localparam logic [TMR_W-1:0] LD_GAP = TMR_W'(GAP_CYC - 1);
  localparam logic [TMR_W-1:0] LD_PWR = TMR_W'(POWERUP_CYC_P - 1);

  typedef struct packed {
    bwe_state_t st;
    bwe_op_t op;
    logic ph;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [7:0] flags;
    logic [IRQ_W-1:0] irq_stat;
    logic [IRQ_W-1:0] irq_mask;
    logic busy_prev;
    bwe_pins_t pins;
  } bwe_host_t;

  localparam bwe_host_t HOST_RST = '{st: S_IDLE, op: OP_NONE, ph: 1'b0, addr: ADDR_RST,
                                     wdata: WDATA_RST, rdata: 8'h00, flags: 8'h00,
                                     irq_stat: '0, irq_mask: IRQ_MASK_RST,
                                     busy_prev: 1'b0, pins: PINS_IDLE};

  bwe_host_t q_r;
  bwe_host_t q_nxt;

  logic [7:0] data_sync;
  logic busy_n_sync;
  logic tmr_done;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_val;
  logic pwr_ok;
  logic dev_busy;
  logic apb_wr;
  logic mapped;

  // pin levels for a state; select is high outside a cycle so the device floats
  function automatic bwe_pins_t drive(bwe_state_t st, bwe_op_t op, logic ph,
                                      logic [7:0] a, logic [7:0] w);
    bwe_pins_t p;
    p = PINS_IDLE;
    if (st != S_IDLE && st != S_GAP) begin
      p.cs_n = 1'b0;
      unique case (op)
        OP_RD_WORD: begin
          // pointer load first, then register file read with port released
          p.rw = ph;
          p.rs = 1'b0;
          p.doe = !ph;
          p.dout = a;
        end
        OP_WR_WORD: begin
          // pointer load, then data-in write starts programming
          p.rw = 1'b0;
          p.rs = ph;
          p.doe = 1'b1;
          p.dout = ph ? w : a;
        end
        OP_RD_STAT: begin
          p.rw = 1'b1;
          p.rs = 1'b1;
        end
        OP_CLEAR: begin
          p.rw = 1'b1;
          p.rs = 1'b1;
          p.clr_n = 1'b0;
        end
        default: begin
          p.cs_n = 1'b1;
        end
      endcase
      p.strobe_pulse_n_n = (st != S_STROBE);
    end
    return p;
  endfunction

  // read phases sample the port instead of strobing it
  function automatic logic is_read(bwe_op_t op, logic ph);
    return (op == OP_RD_STAT) || (op == OP_RD_WORD && ph);
  endfunction

  // pin inputs cross into the clock domain before any logic sees them
  bwe_sync #(.W(8), .RST_VAL(8'h00)) u_data_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i(data_i),
    .sync_o(data_sync)
  );

  bwe_sync #(.W(1), .RST_VAL(1'b1)) u_busy_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .async_i(busy_n_i),
    .sync_o(busy_n_sync)
  );

  // phase timer for setup, strobe, hold, access and recovery
  bwe_timer #(.W(TMR_W), .RST_VAL('0)) u_phase_tmr (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .load_i(tmr_load),
    .load_val_i(tmr_val),
    .done_o(tmr_done)
  );

  // power-up wait, runs once from reset release
  bwe_timer #(.W(TMR_W), .RST_VAL(LD_PWR)) u_pwr_tmr (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .load_i(1'b0),
    .load_val_i('0),
    .done_o(pwr_ok)
  );

  assign dev_busy = !busy_n_sync;
  assign apb_wr = psel_i && penable_i && pwrite_i;

  // next state: apb writes, sequencer and interrupt bookkeeping
  always_comb begin
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] w1c;
    bwe_op_t req;
    q_nxt = q_r;
    ev = '0;
    w1c = '0;
    req = OP_NONE;
    tmr_load = 1'b0;
    tmr_val = '0;
    q_nxt.busy_prev = dev_busy;
    // busy released: programming or clear finished
    if (q_r.busy_prev && !dev_busy) begin
      ev[IRQ_READY] = 1'b1;
    end
    if (apb_wr) begin
      unique case (paddr_i[7:0])
        OFS_CMD: begin
          req = bwe_op_t'(pwdata_i[2:0]);
        end
        OFS_ADDR: begin
          // pointer and data values are frozen while a cycle runs
          if (q_r.st == S_IDLE) begin
            q_nxt.addr = pwdata_i[7:0];
          end
        end
        OFS_WDATA: begin
          if (q_r.st == S_IDLE) begin
            q_nxt.wdata = pwdata_i[7:0];
          end
        end
        OFS_IRQ_STAT: begin
          w1c = pwdata_i[IRQ_W-1:0];
        end
        OFS_IRQ_MASK: begin
          q_nxt.irq_mask = pwdata_i[IRQ_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // start a command; while the device is busy only status reads go out
    if (req == OP_RD_WORD || req == OP_WR_WORD || req == OP_RD_STAT || req == OP_CLEAR) begin
      if (q_r.st == S_IDLE && pwr_ok && !(dev_busy && req != OP_RD_STAT)) begin
        q_nxt.op = req;
        q_nxt.ph = 1'b0;
        q_nxt.st = S_SETUP;
        tmr_load = 1'b1;
        tmr_val = is_read(req, 1'b0) ? LD_READ : LD_SETUP;
      end else begin
        ev[IRQ_REFUSED] = 1'b1;
      end
    end
    // pin sequencer
    unique case (q_r.st)
      S_IDLE: begin
      end
      S_SETUP: begin
        if (tmr_done) begin
          if (is_read(q_r.op, q_r.ph)) begin
            // sample after the access time plus the synchroniser delay
            if (q_r.op == OP_RD_STAT) begin
              q_nxt.flags = data_sync;
            end else begin
              q_nxt.rdata = data_sync;
            end
            q_nxt.st = S_GAP;
            tmr_val = LD_GAP;
          end else begin
            q_nxt.st = S_STROBE;
            tmr_val = LD_STROBE_PULSE_N;
          end
          tmr_load = 1'b1;
        end
      end
      S_STROBE: begin
        if (tmr_done) begin
          q_nxt.st = S_HOLD;
          tmr_load = 1'b1;
          tmr_val = LD_HOLD;
        end
      end
      S_HOLD: begin
        // data stays driven past the rising strobe edge
        if (tmr_done) begin
          q_nxt.st = S_GAP;
          tmr_load = 1'b1;
          tmr_val = LD_GAP;
        end
      end
      S_GAP: begin
        if (tmr_done) begin
          if ((q_r.op == OP_RD_WORD || q_r.op == OP_WR_WORD) && !q_r.ph) begin
            // second cycle of a two-cycle access
            q_nxt.ph = 1'b1;
            q_nxt.st = S_SETUP;
            tmr_load = 1'b1;
            tmr_val = is_read(q_r.op, 1'b1) ? LD_READ : LD_SETUP;
          end else begin
            q_nxt.st = S_IDLE;
            q_nxt.op = OP_NONE;
            ev[IRQ_DONE] = 1'b1;
          end
        end
      end
      default: begin
        q_nxt.st = S_IDLE;
        q_nxt.op = OP_NONE;
      end
    endcase
    // a new event wins over a clear in the same cycle
    q_nxt.irq_stat = (q_r.irq_stat & ~w1c) | ev;
    q_nxt.pins = drive(q_nxt.st, q_nxt.op, q_nxt.ph, q_nxt.addr, q_nxt.wdata);
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      q_r <= HOST_RST;
    end else begin
      q_r <= q_nxt;
    end
  end

  // apb read mux; unmapped offsets answer with an error and zero data
  always_comb begin
    prdata_o = 32'h0000_0000;
    mapped = 1'b1;
    unique case (paddr_i[7:0])
      OFS_CMD: prdata_o = {29'h0, q_r.op};
      OFS_ADDR: prdata_o = {24'h00_0000, q_r.addr};
      OFS_WDATA: prdata_o = {24'h00_0000, q_r.wdata};
      OFS_STATUS: begin
        prdata_o[ST_CTRL_BUSY] = (q_r.st != S_IDLE);
        prdata_o[ST_PWR_OK] = pwr_ok;
        prdata_o[ST_DEV_BUSY] = dev_busy;
        prdata_o[ST_RDATA_LSB +: 8] = q_r.rdata;
        prdata_o[ST_FLAGS_LSB +: 8] = q_r.flags;
      end
      OFS_IRQ_STAT: prdata_o = {29'h0, q_r.irq_stat};
      OFS_IRQ_MASK: prdata_o = {29'h0, q_r.irq_mask};
      default: mapped = 1'b0;
    endcase
  end

  // slave answers in the first access cycle
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i && penable_i && (!mapped || paddr_i[31:8] != 24'h00_0000);
  assign irq_o = |(q_r.irq_stat & q_r.irq_mask);

  // device pins straight from flip-flops
  assign chip_select_n_o = q_r.pins.cs_n;
  assign read_write_o = q_r.pins.rw;
  assign register_select_o = q_r.pins.rs;
  assign strobe_pulse_n_o = q_r.pins.strobe_pulse_n_n;
  assign array_clear_n_o = q_r.pins.clr_n;
  assign data_o = q_r.pins.dout;
  assign data_oe_o = q_r.pins.doe;

endmodule

//--- bwe_host_checker.sv
// bwe_host_checker: pin-level protocol assertions for the eeprom host
`timescale 1ns/1ps
module bwe_host_checker #(
  parameter int unsigned POWERUP_CYC_P = bwe_pkg::POWERUP_CYC
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_i,
  // device pins
  input wire logic chip_select_n_o,
  input wire logic read_write_o,
  input wire logic register_select_o,
  input wire logic strobe_pulse_n_o,
  input wire logic array_clear_n_o,
  input wire logic [7:0] data_o,
  input wire logic data_oe_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (rst_i);

  // edges since reset release, saturating so a long run never wraps
  logic [15:0] up_r;
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      up_r <= 16'h0000;
    end else if (up_r != 16'hFFFF) begin
      up_r <= up_r + 16'h0001;
    end
  end

  // strobe low for its full width, then back high
  sequence strobe_pulse_n_low_s;
    (!strobe_pulse_n_o) [*6];
  endsequence
  sequence strobe_pulse_n_end_s;
    strobe_pulse_n_low_s ##1 strobe_pulse_n_o;
  endsequence

  chk_powerup_quiet: assert property (up_r < 16'(POWERUP_CYC_P) |-> chip_select_n_o)
    else $error("chip selected during power-up delay");
  chk_strobe_selected: assert property (!strobe_pulse_n_o |-> !chip_select_n_o)
    else $error("strobe while deselected");
  chk_drive_write_only: assert property (data_oe_o |-> !read_write_o && !chip_select_n_o)
    else $error("host drives port outside a write");
  chk_clear_pins: assert property (!array_clear_n_o |->
      read_write_o && register_select_o && !chip_select_n_o && !data_oe_o)
    else $error("clear with wrong select pins");
  chk_strobe_width: assert property ($fell(strobe_pulse_n_o) |-> strobe_pulse_n_end_s)
    else $error("strobe width wrong");
  chk_ctrl_steady: assert property (!strobe_pulse_n_o && !$past(strobe_pulse_n_o) |->
      $stable(read_write_o) && $stable(register_select_o) && $stable(data_o))
    else $error("pins moved during strobe");
  chk_data_hold: assert property ($rose(strobe_pulse_n_o) && !read_write_o |->
      data_oe_o ##1 (data_oe_o && $stable(data_o)))
    else $error("write data released too early");
  chk_cycle_gap: assert property ($rose(chip_select_n_o) |-> chip_select_n_o [*7])
    else $error("deselect gap too short");
endmodule

bind bwe_host bwe_host_checker #(.POWERUP_CYC_P(POWERUP_CYC_P)) chk_u (
  .mclk_i, .rst_i, .chip_select_n_o, .read_write_o, .register_select_o,
  .strobe_pulse_n_o, .array_clear_n_o, .data_o, .data_oe_o);

//--- bwe_dev_model.sv
// bwe_dev_model: behavioural byte-wide eeprom register port on the host's pins
`timescale 1ns/1ps
module bwe_dev_model #(
  parameter int unsigned PROG_NS = 4000,
  parameter int unsigned PWR_NS = 500000
) (
  // control pins from the host
  input wire logic cs_n_i,
  input wire logic rw_i,
  input wire logic rs_i,
  input wire logic strobe_pulse_n_n_i,
  input wire logic clr_n_i,
  // shared data port
  input wire logic [7:0] port_i,
  output logic [7:0] drv_o,
  output logic drv_oe_o,
  // busy, already resolved against its pull-up
  output logic busy_n_o
);
  logic [7:0] mem_r [256];
  logic [7:0] ptr_r = 8'h00;
  logic prog_r = 1'b0;

  initial foreach (mem_r[i]) mem_r[i] = 8'hFF;

  // self-timed cycle; a long figure makes the host poll for a while
  task automatic start_prog();
    prog_r = 1'b1;
    fork
      #(PROG_NS) prog_r = 1'b0;
    join_none
  endtask

  // latch on the strobe's rising edge; nothing is taken while deselected or busy
  always @(posedge strobe_pulse_n_n_i) begin
    if (!cs_n_i && !prog_r && $time >= PWR_NS) begin
      if (!rw_i && !rs_i) begin
        ptr_r = port_i;
      end else if (!rw_i) begin
        mem_r[ptr_r] = port_i;
        start_prog();
      end else if (rs_i && !clr_n_i) begin
        foreach (mem_r[i]) mem_r[i] = 8'h00;
        start_prog();
      end
    end
  end

  // status answers any time; file data only when idle; clear floats the port
  assign drv_oe_o = !cs_n_i && rw_i && clr_n_i && (rs_i || !prog_r);
  assign drv_o = rs_i ? {prog_r, 7'h00} : mem_r[ptr_r];
  assign busy_n_o = !prog_r;
endmodule

//--- tb_top.sv
// tb_top: apb-driven bench for the eeprom host with a device model on its pins
`timescale 1ns/1ps
module tb_top;
  import bwe_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] paddr = 32'h0000_0000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdv;
  logic pready, pslverr, irq, erv;
  logic cs_n, rw, rs, strobe_pulse_n_n, clr_n, hoe, doe, busy_n;
  logic [7:0] hd, dd, port_w;
  logic [7:0] pat_r = 8'h00;
  int errors = 0;
  int cmp_count = 0;

  always #25 mclk_i = ~mclk_i;
  // a released port shows a moving pattern, never the last driven byte
  always @(posedge mclk_i) pat_r <= pat_r + 8'h35;
  assign port_w = hoe ? hd : (doe ? dd : pat_r);

  bwe_host #(.POWERUP_CYC_P(20)) dut_u (
    .mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .irq_o(irq), .chip_select_n_o(cs_n), .read_write_o(rw),
    .register_select_o(rs), .strobe_pulse_n_o(strobe_pulse_n_n), .array_clear_n_o(clr_n),
    .data_i(port_w), .data_o(hd), .data_oe_o(hoe), .busy_n_i(busy_n));
  bwe_dev_model #(.PROG_NS(4000), .PWR_NS(1000)) dev_u (
    .cs_n_i(cs_n), .rw_i(rw), .rs_i(rs), .strobe_pulse_n_n_i(strobe_pulse_n_n), .clr_n_i(clr_n),
    .port_i(port_w), .drv_o(dd), .drv_oe_o(doe), .busy_n_o(busy_n));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one apb transfer: setup, then access held until pready is sampled high
  // no local bound on the wait: only the watchdog may end a transfer that never completes
  task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    psel <= 1'b1;
    pwrite <= wr_en;
    paddr <= {24'h00_0000, a};
    pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    do begin
      @(posedge mclk_i);
    end while (pready !== 1'b1);
    rdv = prdata;
    erv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask

  // bounded polling; the bound only guards against a hang
  task automatic poll(input logic [7:0] a, input int b, input logic v);
    int n;
    n = 0;
    do begin
      rd(a);
      n++;
    end while (rdv[b] !== v && n < 500);
    chk(32'(rdv[b]), 32'(v));
  endtask

  // load pointer and data, start a command, wait for done, clear it, read status
  task automatic op(input bwe_op_t o, input logic [7:0] a, input logic [7:0] d);
    wr(OFS_ADDR, {24'h00_0000, a});
    wr(OFS_WDATA, {24'h00_0000, d});
    wr(OFS_CMD, {29'h0000_0000, o});
    rd(OFS_STATUS);
    chk(32'(rdv[ST_CTRL_BUSY]), 32'h0000_0001);
    poll(OFS_IRQ_STAT, IRQ_DONE, 1'b1);
    chk(32'(irq), 32'h0000_0001);
    wr(OFS_IRQ_STAT, 32'h0000_0001);
    rd(OFS_STATUS);
    chk(32'(irq), 32'h0000_0000);
  endtask

  task automatic results();
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(OFS_STATUS);
    chk(32'(rdv[ST_PWR_OK]), 32'h0000_0000);
    wr(OFS_CMD, 32'h0000_0003);
    rd(OFS_IRQ_STAT);
    chk(rdv, 32'h0000_0004);
    chk(32'(irq), 32'h0000_0000);
    wr(OFS_IRQ_STAT, 32'h0000_0007);
    poll(OFS_STATUS, ST_PWR_OK, 1'b1);
    wr(OFS_IRQ_MASK, 32'h0000_0001);
    op(OP_WR_WORD, 8'h5A, 8'hC3);
    op(OP_RD_STAT, 8'h00, 8'h00);
    chk(32'(rdv[23:16]), 32'h0000_0080);
    wr(OFS_CMD, 32'h0000_0001);
    rd(OFS_IRQ_STAT);
    chk(rdv, 32'h0000_0004);
    wr(OFS_IRQ_STAT, 32'h0000_0004);
    poll(OFS_STATUS, ST_DEV_BUSY, 1'b0);
    rd(OFS_IRQ_STAT);
    chk(32'(rdv[IRQ_READY]), 32'h0000_0001);
    op(OP_WR_WORD, 8'h5B, 8'h11);
    poll(OFS_STATUS, ST_DEV_BUSY, 1'b0);
    op(OP_RD_WORD, 8'h5A, 8'h00);
    chk(32'(rdv[15:8]), 32'h0000_00C3);
    op(OP_RD_WORD, 8'h5B, 8'h00);
    chk(32'(rdv[15:8]), 32'h0000_0011);
    op(OP_CLEAR, 8'h00, 8'h00);
    op(OP_RD_STAT, 8'h00, 8'h00);
    chk(32'(rdv[23:16]), 32'h0000_0080);
    poll(OFS_STATUS, ST_DEV_BUSY, 1'b0);
    op(OP_RD_WORD, 8'h5A, 8'h00);
    chk(32'(rdv[15:8]), 32'h0000_0000);
    op(OP_RD_STAT, 8'h00, 8'h00);
    chk(32'(rdv[23:16]), 32'h0000_0000);
    rd(8'h18);
    chk(rdv, 32'h0000_0000);
    chk(32'(erv), 32'h0000_0001);
    results();
  end

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge mclk_i);
    errors++;
    results();
  end
endmodule
